// [iotsd_display.sv]
// Encodes drive terminal states into a four-digit seven-segment monitor image.
// Assumes terminal inputs are already synchronous to sys_clk and active high.
//
// What this block does
// - Operator selects segment view or hex view.
// - Digit one segments a-e show five inputs.
// - Digit three segment a shows transistor output.
// - Digit four segment a shows relay contact.
// - In segment view, all signals off lights dashes everywhere.
// - Digit two f, g, dp show link commands.
// - Hex view packs sixteen bits, top nibble left.
// - Unassigned hex bits read zero.
// - Forward bit 0, backward 1, generals 2-4.
// - Input bit is one while terminal shorted.
// - Output word bit 0 is transistor output.
// - Output word bit 8 is relay contact.
// - Link clear, backward, forward at 15-13.
// - Link control adds the three link commands.
// - Link commands shown uninverted, as received.
// - Each nibble shown as one hex glyph.
`timescale 1ns/1ns
`include "iotsd_map.svh"
module iotsd_display
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        forwardRunInput,
    input  wire logic        backwardRunInput,
    input  wire logic        generalInputOne,
    input  wire logic        generalInputTwo,
    input  wire logic        generalInputThree,
    input  wire logic        transistorOutput,
    input  wire logic        alarmRelayContact,
    input  wire logic        commForwardCommand,
    input  wire logic        commBackwardCommand,
    input  wire logic        commFaultClearCommand,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    output logic      [31:0] regRdData,
    output logic      [31:0] ledImage
);

    logic [2:0]              ctrlValue;
    logic                    ctrlWrite;
    iotsd_pkg::iotsd_view_t  view_reg;
    logic                    wordSel_reg;
    logic                    commMode_reg;
    iotsd_pkg::iotsd_word_t  inWord_reg;
    iotsd_pkg::iotsd_word_t  inWord_next;
    iotsd_pkg::iotsd_word_t  outWord_reg;
    iotsd_pkg::iotsd_word_t  outWord_next;
    logic [31:0]             ledImage_reg;
    logic [31:0]             ledImage_next;
    logic [31:0]             regRdData_reg;
    logic [31:0]             regRdData_next;
    iotsd_pkg::iotsd_view_t  view;
    logic                    commMode;
    logic                    allOff;
    logic                    inIdle;
    logic                    outIdle;
    iotsd_pkg::iotsd_seg_t   digitOne;
    iotsd_pkg::iotsd_seg_t   digitTwo;
    iotsd_pkg::iotsd_seg_t   digitThree;
    iotsd_pkg::iotsd_seg_t   digitFour;
    logic [31:0]             segImage;
    logic [31:0]             hexImage;

    iotsd_glyph_if glyphBus ();

    iotsd_hex_decoder uDecoder
    (
        .glyphBus (glyphBus)
    );

    assign ctrlWrite = regWrStrobe && (regAddr == `IOTSD_ADDR_CTRL);
    assign commMode  = commMode_reg;
    assign view      = view_reg;
    assign ctrlValue = {commMode_reg, wordSel_reg, view_reg == iotsd_pkg::IOTSD_VIEW_HEX};

    // View select of the control register: segment image or hex word.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            view_reg <= iotsd_pkg::IOTSD_VIEW_SEG;
        else if (ctrlWrite)
            view_reg <= regWrData[`IOTSD_CTRL_HEX] ? iotsd_pkg::IOTSD_VIEW_HEX
                                                   : iotsd_pkg::IOTSD_VIEW_SEG;
    end

    // Word select of the control register: input word or output word.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            wordSel_reg <= `IOTSD_CTRL_SEL_RESET;
        else if (ctrlWrite)
            wordSel_reg <= regWrData[`IOTSD_CTRL_OUT_WORD];
    end

    // Link control bit of the control register; it gates the link commands.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            commMode_reg <= `IOTSD_CTRL_COMM_RESET;
        else if (ctrlWrite)
            commMode_reg <= regWrData[`IOTSD_CTRL_COMM];
    end

    // Input word: unlisted bits stay zero, link bits only under link control.
    always_comb
    begin
        inWord_next                     = `IOTSD_WORD_RESET;
        inWord_next[`IOTSD_IN_FWD]      = forwardRunInput;
        inWord_next[`IOTSD_IN_REV]      = backwardRunInput;
        inWord_next[`IOTSD_IN_GEN1]     = generalInputOne;
        inWord_next[`IOTSD_IN_GEN2]     = generalInputTwo;
        inWord_next[`IOTSD_IN_GEN3]     = generalInputThree;
        inWord_next[`IOTSD_IN_COMM_FWD] = commMode & commForwardCommand;
        inWord_next[`IOTSD_IN_COMM_REV] = commMode & commBackwardCommand;
        inWord_next[`IOTSD_IN_COMM_CLR] = commMode & commFaultClearCommand;
    end

    always_comb
    begin
        outWord_next                        = `IOTSD_WORD_RESET;
        outWord_next[`IOTSD_OUT_TRANSISTOR] = transistorOutput;
        outWord_next[`IOTSD_OUT_RELAY]      = alarmRelayContact;
    end

    // Input terminal states are sampled every cycle.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            inWord_reg <= `IOTSD_WORD_RESET;
        else
            inWord_reg <= inWord_next;
    end

    // Output terminal states are sampled every cycle.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            outWord_reg <= `IOTSD_WORD_RESET;
        else
            outWord_reg <= outWord_next;
    end

    assign inIdle  = (inWord_reg == `IOTSD_WORD_RESET);
    assign outIdle = (outWord_reg == `IOTSD_WORD_RESET);
    assign allOff  = inIdle && outIdle;

    // Rightmost digit: run and general inputs, or a dash.
    always_comb
    begin
        digitOne = `IOTSD_DIGIT_DARK;
        if (allOff)
            digitOne[`IOTSD_SEG_G] = 1'b1;
        else
        begin
            digitOne[`IOTSD_SEG_A] = inWord_reg[`IOTSD_IN_FWD];
            digitOne[`IOTSD_SEG_B] = inWord_reg[`IOTSD_IN_REV];
            digitOne[`IOTSD_SEG_C] = inWord_reg[`IOTSD_IN_GEN1];
            digitOne[`IOTSD_SEG_D] = inWord_reg[`IOTSD_IN_GEN2];
            digitOne[`IOTSD_SEG_E] = inWord_reg[`IOTSD_IN_GEN3];
        end
    end

    // Second digit: the three link commands, or a dash.
    always_comb
    begin
        digitTwo = `IOTSD_DIGIT_DARK;
        if (allOff)
            digitTwo[`IOTSD_SEG_G] = 1'b1;
        else
        begin
            digitTwo[`IOTSD_SEG_F]  = inWord_reg[`IOTSD_IN_COMM_FWD];
            digitTwo[`IOTSD_SEG_G]  = inWord_reg[`IOTSD_IN_COMM_REV];
            digitTwo[`IOTSD_SEG_DP] = inWord_reg[`IOTSD_IN_COMM_CLR];
        end
    end

    // Third digit: the transistor output, or a dash.
    always_comb
    begin
        digitThree = `IOTSD_DIGIT_DARK;
        if (allOff)
            digitThree[`IOTSD_SEG_G] = 1'b1;
        else
        begin
            digitThree[`IOTSD_SEG_A] = outWord_reg[`IOTSD_OUT_TRANSISTOR];
        end
    end

    // Leftmost digit: the relay contact, or a dash.
    always_comb
    begin
        digitFour = `IOTSD_DIGIT_DARK;
        if (allOff)
            digitFour[`IOTSD_SEG_G] = 1'b1;
        else
        begin
            digitFour[`IOTSD_SEG_A] = outWord_reg[`IOTSD_OUT_RELAY];
        end
    end

    // Segment view image; digit four in the top byte, digit one in the bottom.
    assign segImage = {digitFour, digitThree, digitTwo, digitOne};

    // Hex view shows the input word or the output word as chosen.
    assign glyphBus.word = wordSel_reg ? outWord_reg : inWord_reg;

    // Decimal points stay dark in hex view.
    assign hexImage = {1'b0, glyphBus.glyphs[27:21],
                       1'b0, glyphBus.glyphs[20:14],
                       1'b0, glyphBus.glyphs[13:7],
                       1'b0, glyphBus.glyphs[6:0]};

    always_comb
    begin
        case (view)
            iotsd_pkg::IOTSD_VIEW_SEG: ledImage_next = segImage;
            iotsd_pkg::IOTSD_VIEW_HEX: ledImage_next = hexImage;
            default:                   ledImage_next = `IOTSD_IMAGE_RESET;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ledImage_reg <= `IOTSD_IMAGE_RESET;
        else
            ledImage_reg <= ledImage_next;
    end

    assign ledImage = ledImage_reg;

    // Read data stands in the cycle after the read strobe only.
    always_comb
    begin
        regRdData_next = `IOTSD_RDATA_RESET;
        if (regRdStrobe)
        begin
            case (regAddr)
                `IOTSD_ADDR_CTRL:     regRdData_next = {29'h0, ctrlValue};
                `IOTSD_ADDR_IN_WORD:  regRdData_next = {16'h0000, inWord_reg};
                `IOTSD_ADDR_OUT_WORD: regRdData_next = {16'h0000, outWord_reg};
                `IOTSD_ADDR_IMAGE:    regRdData_next = ledImage_reg;
                default:              regRdData_next = `IOTSD_RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            regRdData_reg <= `IOTSD_RDATA_RESET;
        else
            regRdData_reg <= regRdData_next;
    end

    assign regRdData = regRdData_reg;

endmodule

// [iotsd_display_asserts.sv]
// Checker bound to the terminal status display ports.
// Assumes control is written only at offset 0x00 and is zero after reset.
`timescale 1ns/1ns
module iotsd_display_asserts
(
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        forwardRunInput,
    input wire logic        backwardRunInput,
    input wire logic        generalInputOne,
    input wire logic        generalInputTwo,
    input wire logic        generalInputThree,
    input wire logic        transistorOutput,
    input wire logic        alarmRelayContact,
    input wire logic        commForwardCommand,
    input wire logic        commBackwardCommand,
    input wire logic        commFaultClearCommand,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrStrobe,
    input wire logic        regRdStrobe,
    input wire logic [31:0] regRdData,
    input wire logic [31:0] ledImage
);
    logic      [2:0] ctrlMirror;
    logic      [1:0] upCnt;
    wire logic [4:0] inBits = {generalInputThree, generalInputTwo, generalInputOne,
                               backwardRunInput, forwardRunInput};
    wire logic [2:0] lnk    = {commFaultClearCommand, commBackwardCommand, commForwardCommand};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrlMirror <= 3'h0;
        else if (regWrStrobe && regAddr == 8'h00)
            ctrlMirror <= regWrData[2:0];
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            upCnt <= 2'h0;
        else if (upCnt != 2'h3)
            upCnt <= upCnt + 2'h1;
    end
    sequence segView;
        upCnt == 2'h3 && !$past(ctrlMirror[0]);
    endsequence
    sequence rdAt(logic [7:0] a);
        upCnt == 2'h3 && regRdStrobe && regAddr == a;
    endsequence
    chk_seg_inputs: assert property (segView |-> ledImage[4:0] == $past(inBits, 2))
        else $error("input segments wrong");
    chk_seg_transistor: assert property (segView |-> ledImage[16] == $past(transistorOutput, 2))
        else $error("transistor segment wrong");
    chk_seg_relay: assert property (segView |-> ledImage[24] == $past(alarmRelayContact, 2))
        else $error("relay segment wrong");
    chk_seg_dash: assert property (segView ##0 ($past({inBits, transistorOutput,
        alarmRelayContact}, 2) == 7'h00 && ($past(lnk, 2) & {3{$past(ctrlMirror[2], 2)}}) == 3'h0)
        |-> ledImage == 32'h4040_4040)
        else $error("dash row missing");
    chk_link_seg: assert property (segView ##0 ($past(inBits, 2) != 5'h00) |->
        ledImage[15:13] == ($past(lnk, 2) & {3{$past(ctrlMirror[2], 2)}}))
        else $error("link segments wrong");
    chk_unused_dark: assert property (segView ##0 ($past(inBits, 2) != 5'h00) |->
        (ledImage & 32'hfefe_1fe0) == 32'h0)
        else $error("unassigned segment lit");
    chk_rd_inword: assert property (rdAt(8'h04) |=> regRdData == {16'h0,
        $past(lnk, 2) & {3{$past(ctrlMirror[2], 2)}}, 8'h00, $past(inBits, 2)})
        else $error("input word wrong");
    chk_rd_outword: assert property (rdAt(8'h08) |=> regRdData == {23'h0,
        $past(alarmRelayContact, 2), 7'h00, $past(transistorOutput, 2)})
        else $error("output word wrong");
    chk_rd_idle: assert property ((!regRdStrobe) or rdAt(8'h10) |=> regRdData == 32'h0)
        else $error("read data not zero");
endmodule
bind iotsd_display iotsd_display_asserts chk (.sys_clk, .arst_n, .forwardRunInput,
    .backwardRunInput, .generalInputOne, .generalInputTwo, .generalInputThree,
    .transistorOutput, .alarmRelayContact, .commForwardCommand, .commBackwardCommand,
    .commFaultClearCommand, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe,
    .regRdData, .ledImage);

// [iotsd_display_tb.sv]
// Self-checking bench of the terminal status display.
// Assumes the checker is bound to the design and the monitor model sits beside it.
`timescale 1ns/1ns
module iotsd_display_tb;
    logic        sys_clk, arst_n, regWrStrobe, regRdStrobe, dashRow;
    logic [7:0]  regAddr;
    logic [9:0]  pins, np;
    logic [2:0]  c;
    logic [15:0] iw, ow;
    logic [31:0] regWrData, regRdData, ledImage, rdVal, seed, ex;
    logic [2:0]  ctrlTab [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7, 3'h2};
    int          error_cnt, samples_checked;
    wire logic   forwardRunInput, backwardRunInput, generalInputOne, generalInputTwo;
    wire logic   generalInputThree, transistorOutput, alarmRelayContact;
    wire logic   commForwardCommand, commBackwardCommand, commFaultClearCommand;
    assign {commFaultClearCommand, commBackwardCommand, commForwardCommand, alarmRelayContact,
            transistorOutput, generalInputThree, generalInputTwo, generalInputOne,
            backwardRunInput, forwardRunInput} = pins;
    iotsd_display uut (.sys_clk, .arst_n, .forwardRunInput, .backwardRunInput, .generalInputOne,
        .generalInputTwo, .generalInputThree, .transistorOutput, .alarmRelayContact,
        .commForwardCommand, .commBackwardCommand, .commFaultClearCommand, .regAddr,
        .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .ledImage);
    iotsd_led_monitor mon (.sys_clk, .ledImage, .dashRow);
    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] gl(logic [3:0] n);
        logic [7:0] t [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                               8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
        return t[n];
    endfunction
    function automatic logic [31:0] model(logic [2:0] k, logic [15:0] i, logic [15:0] o);
        logic [15:0] w;
        w = k[1] ? o : i;
        if (k[0])
            return {gl(w[15:12]), gl(w[11:8]), gl(w[7:4]), gl(w[3:0])};
        if (i == 16'h0 && o == 16'h0)
            return 32'h4040_4040;
        return {7'h00, o[8], 7'h00, o[0], i[15:13], 8'h00, i[4:0]};
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial
    begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        {arst_n, regWrStrobe, regRdStrobe, regAddr, regWrData, pins} = '0;
        seed = 32'h0000_1d06;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 56; i++)
        begin
            seed = xs(seed);
            c = ctrlTab[i % 7];
            np = (i % 4 == 0) ? 10'h000 : seed[13:4];
            iw = {np[9:7] & {3{c[2]}}, 8'h00, np[4:0]};
            ow = {7'h00, np[6], 7'h00, np[5]};
            ex = model(c, iw, ow);
            wr(8'h00, {seed[31:3], c});
            wr(8'h20, 32'h0000_0007);
            pins <= np;
            repeat (4) @(posedge sys_clk);
            #1;
            chk("ledImage", ex, ledImage);
            chk("dashRow", {31'h0, ex == 32'h4040_4040}, {31'h0, dashRow});
            rd(8'h00);
            chk("ctrl", {29'h0, c}, rdVal);
            rd(8'h04);
            chk("inWord", {16'h0, iw}, rdVal);
            rd(8'h08);
            chk("outWord", {16'h0, ow}, rdVal);
            rd(8'h0c);
            chk("image", ex, rdVal);
            rd(8'h10);
            chk("unmapped", 32'h0, rdVal);
        end
        print_verdict();
    end
endmodule

// [iotsd_glyph_if.sv]
// Carrier between the display encoder and its hexadecimal glyph decoder.
// Assumes both ends sit in the same clock domain; the decoder is combinational.
`timescale 1ns/1ns
interface iotsd_glyph_if;
    iotsd_pkg::iotsd_word_t word;
    logic [27:0]            glyphs;

    modport enc (output word, input glyphs);
    modport dec (input word, output glyphs);
endinterface

// [iotsd_hex_decoder.sv]
// Turns a 16-bit word into four seven-segment hexadecimal glyphs.
// Assumes segment a in bit 0 through segment g in bit 6; no clock needed.
`timescale 1ns/1ns
module iotsd_hex_decoder
(
    iotsd_glyph_if.dec glyphBus
);

    function automatic logic [6:0] hexGlyph(input logic [3:0] nibble);
        logic [6:0] g;
        g = 7'h00;
        case (nibble)
            4'h0:    g = 7'h3f;
            4'h1:    g = 7'h06;
            4'h2:    g = 7'h5b;
            4'h3:    g = 7'h4f;
            4'h4:    g = 7'h66;
            4'h5:    g = 7'h6d;
            4'h6:    g = 7'h7d;
            4'h7:    g = 7'h07;
            4'h8:    g = 7'h7f;
            4'h9:    g = 7'h6f;
            4'ha:    g = 7'h77;
            4'hb:    g = 7'h7c;
            4'hc:    g = 7'h39;
            4'hd:    g = 7'h5e;
            4'he:    g = 7'h79;
            4'hf:    g = 7'h71;
            default: g = 7'h00;
        endcase
        return g;
    endfunction

    // Each nibble becomes one digit, covering all sixteen values.
    genvar d;
    generate
        for (d = 0; d < 4; d++)
        begin : gDigit
            assign glyphBus.glyphs[d*7 +: 7] = hexGlyph(glyphBus.word[d*4 +: 4]);
        end
    endgenerate

endmodule

// [iotsd_led_monitor.sv]
// Behavioural model of the four-digit monitor fed by the image.
// Assumes one byte per digit, bit 0 segment a up to bit 7 the point.
`timescale 1ns/1ns
module iotsd_led_monitor
(
    input wire logic        sys_clk,
    input wire logic [31:0] ledImage,
    output logic            dashRow
);
    // Registers only a flag, set when the image is a row of dashes.
    always_ff @(posedge sys_clk)
    begin
        dashRow <= (ledImage == 32'h4040_4040);
    end
endmodule

// [iotsd_map.svh]
// Offsets, field positions and reset values of the terminal status display.
// Assumes it is included by bare name after the package and before use.
`ifndef IOTSD_MAP_SVH
`define IOTSD_MAP_SVH

`define IOTSD_ADDR_CTRL       8'h00
`define IOTSD_ADDR_IN_WORD    8'h04
`define IOTSD_ADDR_OUT_WORD   8'h08
`define IOTSD_ADDR_IMAGE      8'h0c

`define IOTSD_CTRL_HEX        0
`define IOTSD_CTRL_OUT_WORD   1
`define IOTSD_CTRL_COMM       2
`define IOTSD_CTRL_RESET      3'h0
`define IOTSD_CTRL_SEL_RESET  1'b0
`define IOTSD_CTRL_COMM_RESET 1'b0
`define IOTSD_DIGIT_DARK      8'h00

`define IOTSD_IN_FWD          0
`define IOTSD_IN_REV          1
`define IOTSD_IN_GEN1         2
`define IOTSD_IN_GEN2         3
`define IOTSD_IN_GEN3         4
`define IOTSD_IN_COMM_FWD     13
`define IOTSD_IN_COMM_REV     14
`define IOTSD_IN_COMM_CLR     15
`define IOTSD_OUT_TRANSISTOR  0
`define IOTSD_OUT_RELAY       8

`define IOTSD_SEG_A           0
`define IOTSD_SEG_B           1
`define IOTSD_SEG_C           2
`define IOTSD_SEG_D           3
`define IOTSD_SEG_E           4
`define IOTSD_SEG_F           5
`define IOTSD_SEG_G           6
`define IOTSD_SEG_DP          7

`define IOTSD_WORD_RESET      16'h0000
`define IOTSD_IMAGE_RESET     32'h0000_0000
`define IOTSD_RDATA_RESET     32'h0000_0000

`endif

// [iotsd_pkg.sv]
// Types shared by the terminal status display modules.
// Assumes the constants of iotsd_map.svh for field positions.
package iotsd_pkg;

    typedef enum logic [1:0] {
        IOTSD_VIEW_SEG = 2'b01,
        IOTSD_VIEW_HEX = 2'b10
    } iotsd_view_t;

    typedef logic [7:0]  iotsd_seg_t;
    typedef logic [15:0] iotsd_word_t;

endpackage
